// ---- rtl/sam_read_port.v ----
// device-side read port of a split address / data multiplexed flash bus
`timescale 1ns/1ps
`include "sam_defs.vh"
module sam_read_port #(
    parameter BUS_W   = `SAM_BUS_W,
    parameter LATENCY = `SAM_LATENCY,
    parameter DEPTH   = `SAM_FIFO_DEPTH
) (
    // clock and reset
    input  wire             CLK,
    input  wire             RESET_N,
    // memory bus pins
    input  wire             CHIP_SELECT_N,
    input  wire             ADDRESS_VALID_N,
    input  wire             OUTPUT_ENABLE_N,
    input  wire             WRITE_ENABLE_N,
    input  wire [BUS_W-1:0] BUS_IN,
    output reg  [BUS_W-1:0] BUS_OUT,
    output reg              BUS_OE,
    output reg              READY,
    // array side: address out, data in through the fifo
    output reg  [2*BUS_W-1:0] ARRAY_ADDR,
    output reg              ARRAY_REQ,
    input  wire             ARRAY_VALID,
    output wire             ARRAY_READY,
    input  wire [BUS_W-1:0] ARRAY_DATA
);
    // ------------------------------------------------------------------------
    // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
    // ------------------------------------------------------------------------
    localparam PW = BUS_W + 4;
    wire [PW-1:0] pin_raw = {CHIP_SELECT_N, ADDRESS_VALID_N, OUTPUT_ENABLE_N,
                             WRITE_ENABLE_N, BUS_IN};
    reg  [PW-1:0] s1;
    reg  [PW-1:0] s2;
    reg  [PW-1:0] s3;
    reg  [PW-1:0] pin;

    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s1  <= {PW{1'b1}};
            s2  <= {PW{1'b1}};
            s3  <= {PW{1'b1}};
            pin <= {PW{1'b1}};
        end
        else
        begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
            pin <= (s2 & s3) | (pin & (s2 ^ s3));
        end
    end

    wire             cs_n  = pin[PW-1];
    wire             avd_n = pin[PW-2];
    wire             oe_n  = pin[PW-3];
    wire             we_n  = pin[PW-4];
    wire [BUS_W-1:0] bus   = pin[BUS_W-1:0];

    // strobes only count while chip select is low
    wire sel       = ~cs_n;                          // RULE6
    wire upper_ph  = sel & ~avd_n & ~oe_n;           // RULE1
    wire lower_ph  = sel & ~avd_n & oe_n & we_n;     // RULE3

    // ------------------------------------------------------------------------
    // address capture and burst sequencing
    // ------------------------------------------------------------------------
    reg [BUS_W-1:0] upper;
    reg [1:0]       state;
    reg [7:0]       lat_cnt;
    reg             oe_armed;
    reg             fifo_flush;
    reg             lower_seen;
    reg             gate_used;
    wire            f_valid;
    wire [BUS_W-1:0] f_data;
    wire            f_pop = (state == `SAM_ST_BURST) & sel & ~oe_n & oe_armed & f_valid;
    // one request per address phase, however long the host holds it
    wire            lower_start = lower_ph & ~lower_seen;

    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            upper      <= {BUS_W{1'b0}};
            ARRAY_ADDR <= {(2*BUS_W){1'b0}};
            ARRAY_REQ  <= 1'b0;
            state      <= `SAM_ST_IDLE;
            lat_cnt    <= 8'h00;
            oe_armed   <= 1'b0;
            fifo_flush <= 1'b0;
            lower_seen <= 1'b0;
            gate_used  <= 1'b0;
            BUS_OUT    <= {BUS_W{1'b0}};
            BUS_OE     <= 1'b0;
            READY      <= 1'b0;
        end
        else
        begin
            ARRAY_REQ  <= 1'b0;
            fifo_flush <= 1'b0;
            lower_seen <= lower_ph;
            if (upper_ph)
                upper <= bus;                                        // RULE1
            if (!sel)
            begin
                // deselect ends the access and releases the bus
                state    <= `SAM_ST_IDLE;
                oe_armed <= 1'b0;
                BUS_OE   <= 1'b0;
                READY    <= 1'b0;
            end
            else if (lower_start)
            begin
                // the held upper part is reused when no upper phase came
                ARRAY_ADDR <= {upper, bus};                          // RULE2
                ARRAY_REQ  <= 1'b1;
                fifo_flush <= 1'b1;
                state      <= `SAM_ST_WAIT;
                lat_cnt    <= 8'h01;                                  // RULE5
                oe_armed   <= 1'b1;                                   // RULE3
                gate_used  <= 1'b0;
                BUS_OE     <= 1'b0;
                READY      <= 1'b0;
            end
            else
            begin
                // a gate that was never lowered for this access has not returned high
                if (oe_armed && !oe_n)
                    gate_used <= 1'b1;
                // gate released between accesses: disarm until next lower phase
                if (oe_n && gate_used)
                    oe_armed <= 1'b0;                                 // RULE4
                case (state)
                `SAM_ST_IDLE:
                begin
                    BUS_OE <= 1'b0;
                    READY  <= 1'b0;
                end
                `SAM_ST_WAIT:
                begin
                    if (lat_cnt >= LATENCY[7:0] - 8'h01)
                        state <= `SAM_ST_BURST;                      // RULE5
                    else
                        lat_cnt <= lat_cnt + 8'h01;
                end
                `SAM_ST_BURST:
                begin
                    BUS_OE <= oe_armed & ~oe_n;                      // RULE3 RULE4
                    READY  <= f_pop;
                    if (f_pop)
                        BUS_OUT <= f_data;
                end
                default:
                    state <= `SAM_ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // read data buffer; host output gate drains it, array stalls when full
    // ------------------------------------------------------------------------
    sam_fifo #(
        .WIDTH (BUS_W),
        .DEPTH (DEPTH),
        .AW    (4)
    ) u_fifo (
        .CLK       (CLK),
        .RESET_N   (RESET_N),
        .IN_VALID  (ARRAY_VALID),
        .IN_READY  (ARRAY_READY),
        .IN_DATA   (ARRAY_DATA),
        .OUT_VALID (f_valid),
        .OUT_READY (f_pop),
        .OUT_DATA  (f_data),
        .FLUSH     (fifo_flush)
    );
endmodule

// ----------------------------------------------------------------------------
// read data fifo: valid/ready on both sides, flush drops everything held
// ----------------------------------------------------------------------------
module sam_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             CLK,
    input  wire             RESET_N,
    // fill side
    input  wire             IN_VALID,
    output wire             IN_READY,
    input  wire [WIDTH-1:0] IN_DATA,
    // drain side
    output wire             OUT_VALID,
    input  wire             OUT_READY,
    output wire [WIDTH-1:0] OUT_DATA,
    // flush
    input  wire             FLUSH
);
    localparam LAST = DEPTH - 1;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign IN_READY  = (count != DEPTH[AW:0]);
    assign OUT_VALID = (count != {(AW+1){1'b0}});
    assign OUT_DATA  = mem[rd_ptr];
    assign push      = IN_VALID & IN_READY;
    assign pop       = OUT_VALID & OUT_READY;

    // storage has no reset: count and the read pointer say which slots hold data
    always @(posedge CLK)
    begin
        if (push)
            mem[wr_ptr] <= IN_DATA;
    end

    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else if (FLUSH)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == LAST[AW-1:0]) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == LAST[AW-1:0]) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// ---- rtl/sam_defs.vh ----
// constants for the split address / data multiplexed synchronous read port
// ----------------------------------------------------------------------------
// Behaviour
// [RULE1] avd low with output gate low latches the bus as upper address
// [RULE2] upper phase optional; a lone lower phase reuses the held upper part
// [RULE3] data drivers turn on only after a lower-address phase was received
// [RULE4] output gate ignored after returning high until next lower-address phase
// [RULE5] latency counts from edge sampling avd low to first data edge; default 15
// [RULE6] bus and strobes sampled on rising edge only while chip select is low
// ----------------------------------------------------------------------------
`ifndef SAM_DEFS_VH
`define SAM_DEFS_VH

`define SAM_BUS_W        16
`define SAM_LATENCY      15
`define SAM_FIFO_DEPTH   16
`define SAM_ST_IDLE      2'h0
`define SAM_ST_WAIT      2'h1
`define SAM_ST_BURST     2'h2

`endif

// ---- rtl/sam_fifo.v ----
// the buffer fifo module sits in the read port file, beside its only user

// ---- dv/sam_checker.sv ----
// timing assertions for the multiplexed read port
`timescale 1ns/1ps
module sam_checker #(
    parameter LATENCY = 15
) (
    input wire CLK, RESET_N, CHIP_SELECT_N, ADDRESS_VALID_N,
    input wire OUTPUT_ENABLE_N, WRITE_ENABLE_N, BUS_OE, READY, ARRAY_REQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    property p_req_pulse; ARRAY_REQ |=> !ARRAY_REQ; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("long request");
    property p_cs_req; CHIP_SELECT_N [*8] |-> !ARRAY_REQ; endproperty
    a_cs_req: assert property (p_cs_req) else $error("request while deselected");
    property p_cs_oe; CHIP_SELECT_N [*7] |-> !BUS_OE; endproperty
    a_cs_oe: assert property (p_cs_oe) else $error("drive while deselected");
    property p_avd_idle; ADDRESS_VALID_N [*8] |-> !ARRAY_REQ; endproperty
    a_avd_idle: assert property (p_avd_idle) else $error("request without address");
    property p_we_block; (!WRITE_ENABLE_N) [*8] |-> !ARRAY_REQ; endproperty
    a_we_block: assert property (p_we_block) else $error("request during write");
    property p_oe_gate; OUTPUT_ENABLE_N [*7] |-> !BUS_OE; endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("drive with gate high");
    // three quiet cycles fit the bench latency of 4
    property p_latency; ARRAY_REQ |=> !READY [*3]; endproperty
    a_latency: assert property (p_latency) else $error("data too early");
    property p_ready_oe; READY |-> BUS_OE; endproperty
    a_ready_oe: assert property (p_ready_oe) else $error("word not driven");
    // edges since the last request, saturating, for the lower latency bound
    reg [7:0] since_req;
    always @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            since_req <= 8'h00;
        else if (ARRAY_REQ)
            since_req <= 8'h01;
        else if (since_req != 8'hff)
            since_req <= since_req + 8'h01;
    end
    property p_min_lat; READY |-> (since_req >= LATENCY); endproperty
    a_min_lat: assert property (p_min_lat) else $error("word before latency");
    c_first: cover property (READY && since_req == LATENCY);
    c_req: cover property (ARRAY_REQ);
    c_word: cover property (READY);
    c_upper: cover property (!CHIP_SELECT_N && !ADDRESS_VALID_N && !OUTPUT_ENABLE_N);
endmodule
bind sam_read_port sam_checker #(.LATENCY(LATENCY)) u_chk (.CLK(CLK), .RESET_N(RESET_N),
    .CHIP_SELECT_N(CHIP_SELECT_N), .ADDRESS_VALID_N(ADDRESS_VALID_N),
    .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .WRITE_ENABLE_N(WRITE_ENABLE_N),
    .BUS_OE(BUS_OE), .READY(READY), .ARRAY_REQ(ARRAY_REQ));

// ---- dv/sam_array_model.sv ----
// array model: streams words for the last requested address
`timescale 1ns/1ps
module sam_array_model (
    input  wire        CLK,
    input  wire        SLOW,
    input  wire        ARRAY_REQ,
    input  wire [31:0] ARRAY_ADDR,
    input  wire        ARRAY_READY,
    output wire        ARRAY_VALID,
    output wire [15:0] ARRAY_DATA
);
    reg [31:0] addr = 32'h0;
    reg [15:0] k = 16'h0;
    reg        run = 1'b0;
    reg        gap = 1'b0;
    wire [15:0] w = (addr[15:0] + k) ^ addr[31:16];
    // valid holds until taken; slow mode idles one cycle after each word
    assign ARRAY_VALID = run && !gap;
    assign ARRAY_DATA = ARRAY_VALID ? w : ~w;
    always @(posedge CLK)
    begin
        gap <= ARRAY_VALID && ARRAY_READY && SLOW;
        if (ARRAY_REQ)
        begin
            addr <= ARRAY_ADDR;
            k <= 16'h0;
            run <= 1'b1;
        end
        else if (ARRAY_VALID && ARRAY_READY)
            k <= k + 16'h1;
    end
endmodule

// ---- dv/sam_read_port_tb.sv ----
// self-checking bench for the multiplexed read port
`timescale 1ns/1ps
module split_addr_mux_sync_read_port_tb_top;
    reg         CLK = 0, RESET_N = 0, CHIP_SELECT_N = 1, ADDRESS_VALID_N = 1;
    reg         OUTPUT_ENABLE_N = 1, WRITE_ENABLE_N = 1, SLOW = 0;
    reg  [15:0] host_bus = 16'h0, held_up = 16'h0;
    wire [15:0] BUS_OUT, ARRAY_DATA;
    wire [31:0] ARRAY_ADDR;
    wire        BUS_OE, READY, ARRAY_REQ, ARRAY_VALID, ARRAY_READY;
    wire [15:0] BUS_IN = BUS_OE ? BUS_OUT : host_bus;
    integer     err_total = 0, check_count = 0, seed = 6945, i, lat;
    localparam  LAT = 4;
    always #5 CLK = ~CLK;
    sam_read_port #(.LATENCY(LAT)) DUT (.CLK(CLK), .RESET_N(RESET_N),
        .CHIP_SELECT_N(CHIP_SELECT_N), .ADDRESS_VALID_N(ADDRESS_VALID_N),
        .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .WRITE_ENABLE_N(WRITE_ENABLE_N),
        .BUS_IN(BUS_IN), .BUS_OUT(BUS_OUT), .BUS_OE(BUS_OE), .READY(READY),
        .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_REQ(ARRAY_REQ), .ARRAY_VALID(ARRAY_VALID),
        .ARRAY_READY(ARRAY_READY), .ARRAY_DATA(ARRAY_DATA));
    sam_array_model MDL (.CLK(CLK), .SLOW(SLOW), .ARRAY_REQ(ARRAY_REQ),
        .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_READY(ARRAY_READY),
        .ARRAY_VALID(ARRAY_VALID), .ARRAY_DATA(ARRAY_DATA));
    task tick; begin @(posedge CLK); #1; end endtask
    task check(input string what, input [15:0] exp, input [15:0] got);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    end
    endtask
    task conclude;
    begin
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    // strobes held three cycles so the pin filter agrees on them
    task phase(input cs, input gate, input [15:0] v);
    begin
        CHIP_SELECT_N = cs; ADDRESS_VALID_N = 0; OUTPUT_ENABLE_N = gate; host_bus = v;
        repeat (3) tick;
        ADDRESS_VALID_N = 1; OUTPUT_ENABLE_N = 1; CHIP_SELECT_N = 0; host_bus = ~v;
        tick;
    end
    endtask
    task quiet;
    begin
        OUTPUT_ENABLE_N = 0;
        repeat (12) begin tick; check("gated", 16'h0, {14'h0, READY, BUS_OE}); end
        OUTPUT_ENABLE_N = 1;
        tick;
        $display("gate quiet test ended");
    end
    endtask
    task rd(input up_on, input [15:0] up, input [15:0] lo, input integer n);
        integer k, t;
    begin
        if (up_on) begin phase(0, 0, up); held_up = up; end
        phase(0, 1, lo);
        repeat (45) tick;
        check("fifo full", 16'h0, {15'h0, ARRAY_READY});
        check("addr low", lo, ARRAY_ADDR[15:0]);
        check("addr high", held_up, ARRAY_ADDR[31:16]);
        OUTPUT_ENABLE_N = 0; k = 0; t = 0;
        while (k < n && t < 300)
        begin
            tick; t = t + 1;
            if (READY === 1'b1) begin check("word", (lo + k) ^ held_up, BUS_OUT); k = k + 1; end
        end
        OUTPUT_ENABLE_N = 1;
        // the raised gate must outlast the pin filter before the next access
        repeat (5) tick;
        $display("read %h:%h ended with %0d words", held_up, lo, k);
        if (k < n) begin check("word count", n, k); conclude; end
    end
    endtask
    initial
    begin
        repeat (5) tick;
        RESET_N = 1;
        repeat (3) tick;
        quiet;
        CHIP_SELECT_N = 0; ADDRESS_VALID_N = 0; WRITE_ENABLE_N = 0;
        repeat (9) tick;
        ADDRESS_VALID_N = 1; WRITE_ENABLE_N = 1;
        tick;
        rd(1, 16'hffff, 16'hfff0, 20);
        rd(0, 16'h0, 16'h0000, 20);
        quiet;
        phase(1, 0, 16'h5a5a);
        rd(0, 16'h0, 16'h0011, 4);
        for (i = 0; i < 6; i = i + 1)
        begin
            SLOW = $random(seed);
            rd($random(seed), $random(seed), $random(seed), 18);
        end
        // gate lowered as the address phase ends: the first word shows the bare latency
        host_bus = 16'h0100;
        ADDRESS_VALID_N = 0;
        repeat (3) tick;
        ADDRESS_VALID_N = 1;
        OUTPUT_ENABLE_N = 0;
        i = 0;
        while (ARRAY_REQ !== 1'b1 && i < 20)
        begin
            tick;
            i = i + 1;
        end
        lat = 0;
        while (READY !== 1'b1 && lat < 40)
        begin
            tick;
            lat = lat + 1;
        end
        check("latency", LAT, lat);
        check("first word", 16'h0100 ^ held_up, BUS_OUT);
        OUTPUT_ENABLE_N = 1;
        repeat (5) tick;
        $display("latency test ended");
        conclude;
    end
endmodule
